// [common/lpo_defs.vh]
// Purpose: constants for the panel output conditioning block
// Assumes: 32-bit register port, word addresses are byte offsets
// Notes: field positions refer to the register bit numbers
`ifndef LPO_DEFS_VH
`define LPO_DEFS_VH
`define LPO_PANEL_CFG_ADDR 8'h0C
`define LPO_DISP_SET_ADDR 8'h10
`define LPO_STATUS_ADDR 8'h14
`define LPO_PANEL_CFG_RST 32'h00000000
`define LPO_DISP_SET_RST 32'h00000000
`define LPO_PT_LSB 0
`define LPO_DW_LSB 4
`define LPO_CFG_RSVD 3
`define LPO_DBL_V 25
`define LPO_DBL_H 24
`define LPO_BLANK 23
`define LPO_DITH_DIS 22
`define LPO_BLANK_POL 21
`define LPO_SOFT_INV 20
`define LPO_ROT_LSB 16
`define LPO_BPP_LSB 0
`define LPO_PT_STN 2'h0
`define LPO_PT_TFT 2'h1
`define LPO_PT_HRA 2'h3
`define LPO_CFG_MASK 32'h00000033
`define LPO_DISP_MASK 32'h03F3001F
`define LPO_FIFO_DEPTH 16
`endif

// [rtl/lpo_fifo.v]
// Purpose: pixel buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes: full and empty come from an occupancy count
`timescale 1ns/100ps
module lpo_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_b,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_reg];
  always @(posedge clk) begin
    if (push)
      mem[wr_reg] <= in_data;
  end
  always @(posedge clk) begin
    if (!rst_b) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

// [rtl/lpo_top.v]
// Purpose: panel configuration registers and pixel output conditioning
// Assumes: pixels arrive after colour lookup, one per valid/ready handshake
// Notes: line doubling replays a stored line; panel side stalls via pix_ready
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`include "lpo_defs.vh"
module lpo_top #(
  parameter LINE_MAX = 1024,
  parameter LW = 10
) (
  input wire clk,
  input wire rst_b,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata,
  input wire [17:0] lut_pixel,
  input wire lut_valid,
  output reg lut_ready,
  input wire line_end,
  output reg [17:0] panel_data_out,
  output reg panel_valid,
  input wire pix_ready,
  output reg [4:0] active_width,
  output reg width_bad,
  output reg type_bad,
  output reg passive_sel
);
  reg [31:0] cfg_reg;
  reg [31:0] disp_reg;
  reg [17:0] line_mem [0:LINE_MAX-1];
  reg [LW-1:0] wptr_reg;
  reg [LW-1:0] rptr_reg;
  reg [LW-1:0] len_reg;
  reg replay_reg;
  reg hrep_reg;
  reg [17:0] hold_reg;
  reg [3:0] frm_reg;
  reg [17:0] pix_next;
  reg [4:0] w_next;
  reg src_take;
  reg push;
  reg hrep_nx;
  reg replay_nx;
  reg [17:0] pix_next_out;
  wire [17:0] fifo_data;
  wire fifo_valid;
  wire fifo_in_ready;
  wire [1:0] ptype = cfg_reg[`LPO_PT_LSB+1:`LPO_PT_LSB];
  wire [1:0] wcode = cfg_reg[`LPO_DW_LSB+1:`LPO_DW_LSB];
  wire is_stn = (ptype == `LPO_PT_STN);
  wire dbl_v = disp_reg[`LPO_DBL_V];
  wire dbl_h = disp_reg[`LPO_DBL_H];
  wire blank = disp_reg[`LPO_BLANK];
  wire dith_dis = disp_reg[`LPO_DITH_DIS];
  wire bpol = disp_reg[`LPO_BLANK_POL];
  wire soft_pixel_complement = disp_reg[`LPO_SOFT_INV];

  // width in lines from code and panel class
  function [4:0] width_of;
    input [1:0] code;
    input passive;
    begin
      case (code)
        2'h0: width_of = passive ? 5'h04 : 5'h09;
        2'h1: width_of = passive ? 5'h08 : 5'h0C;
        2'h2: width_of = passive ? 5'h10 : 5'h12;
        default: width_of = 5'h00;
      endcase
    end
  endfunction

  // ordered dither: add a small bias that steps at each line_end before truncating each 6-bit colour
  function [5:0] dith6;
    input [5:0] c;
    input [1:0] bias;
    reg [6:0] s;
    begin
      s = {1'b0, c} + {5'h00, bias};
      dith6 = s[6] ? 6'h3F : {s[5:2], 2'h0};
    end
  endfunction

  // register port, one-cycle read latency
  always @(posedge clk) begin
    if (!rst_b) begin
      cfg_reg <= `LPO_PANEL_CFG_RST;
      disp_reg <= `LPO_DISP_SET_RST;
      rdata <= 32'h00000000;
    end else begin
      if (wr_stb && addr == `LPO_PANEL_CFG_ADDR)
        cfg_reg <= wdata & `LPO_CFG_MASK;
      if (wr_stb && addr == `LPO_DISP_SET_ADDR)
        disp_reg <= wdata & `LPO_DISP_MASK;
      if (rd_stb) begin
        case (addr)
          `LPO_PANEL_CFG_ADDR: rdata <= cfg_reg;
          `LPO_DISP_SET_ADDR: rdata <= disp_reg;
          `LPO_STATUS_ADDR: rdata <= {26'h0, replay_reg, fifo_valid, type_bad,
                                      width_bad, is_stn, ~fifo_in_ready};
          default: rdata <= 32'h00000000;
        endcase
      end else begin
        rdata <= 32'h00000000;
      end
    end
  end

  // source side: new pixels from the lookup stage, or replay of the stored line
  always @* begin
    src_take = 1'b0;
    push = 1'b0;
    pix_next = replay_reg ? line_mem[rptr_reg] : lut_pixel;
    if (hrep_reg)
      pix_next = hold_reg;
    if (fifo_in_ready) begin
      if (hrep_reg)
        push = 1'b1;
      else if (replay_reg)
        push = 1'b1;
      else if (lut_valid && lut_ready) begin
        push = 1'b1;
        src_take = 1'b1;
      end
    end
    // ready must drop in the same cycle a repeat starts, or the source moves on unseen
    hrep_nx = push ? (dbl_h && !hrep_reg) : hrep_reg;
    replay_nx = replay_reg;
    if (push && !hrep_reg) begin
      if (replay_reg)
        replay_nx = (rptr_reg != len_reg);
      else if (src_take && dbl_v && line_end)
        replay_nx = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (src_take && dbl_v && !hrep_reg)
      line_mem[wptr_reg] <= lut_pixel;
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      wptr_reg <= {LW{1'b0}};
      rptr_reg <= {LW{1'b0}};
      len_reg <= {LW{1'b0}};
      replay_reg <= 1'b0;
      hrep_reg <= 1'b0;
      hold_reg <= 18'h00000;
      lut_ready <= 1'b0;
    end else begin
      lut_ready <= fifo_in_ready && !replay_nx && !hrep_nx;
      if (push) begin
        hold_reg <= pix_next;
        hrep_reg <= dbl_h && !hrep_reg;
      end
      if (push && !hrep_reg) begin
        if (replay_reg) begin
          if (rptr_reg == len_reg) begin
            replay_reg <= 1'b0;
            rptr_reg <= {LW{1'b0}};
          end else
            rptr_reg <= rptr_reg + 1'b1;
        end else if (src_take && dbl_v) begin
          if (line_end) begin
            len_reg <= wptr_reg;
            wptr_reg <= {LW{1'b0}};
            replay_reg <= 1'b1;
          end else if (wptr_reg != LINE_MAX[LW-1:0] - 1'b1)
            wptr_reg <= wptr_reg + 1'b1;
        end
      end
    end
  end

  lpo_fifo #(
    .WIDTH(18),
    .DEPTH(`LPO_FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_data(pix_next),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pix_ready || !panel_valid)
  );

  // output stage: dither, invert, blank, width mask
  always @* begin
    w_next = width_of(wcode, is_stn);
    pix_next_out = fifo_data;
    if (is_stn && !dith_dis) begin
      pix_next_out = {dith6(fifo_data[17:12], frm_reg[1:0]),
                      dith6(fifo_data[11:6], frm_reg[2:1]),
                      dith6(fifo_data[5:0], frm_reg[3:2])};
    end else if (is_stn) begin
      pix_next_out = fifo_data & 18'h3CF3C;
    end
    if (soft_pixel_complement)
      pix_next_out = ~pix_next_out;
    if (blank)
      pix_next_out = {18{bpol ^ soft_pixel_complement}};
    pix_next_out = pix_next_out & ((18'h00001 << w_next) - 18'h00001);
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      panel_data_out <= 18'h00000;
      panel_valid <= 1'b0;
      frm_reg <= 4'h0;
      active_width <= 5'h00;
      width_bad <= 1'b0;
      type_bad <= 1'b0;
      passive_sel <= 1'b1;
    end else begin
      active_width <= width_of(wcode, is_stn);
      width_bad <= (wcode == 2'h3);
      type_bad <= (ptype == 2'h2);
      passive_sel <= is_stn;
      if (fifo_valid && (pix_ready || !panel_valid)) begin
        panel_data_out <= pix_next_out;
        panel_valid <= 1'b1;
        if (line_end)
          frm_reg <= frm_reg + 1'b1;
      end else if (pix_ready)
        panel_valid <= 1'b0;
    end
  end
endmodule

// [verification/lpo_top_properties.sv]
// Purpose: port-level checks for lpo_top
// Assumes: settings change only through writes seen on the register port
// Notes: both registers are shadowed here; age counts cycles since any write
`timescale 1ns/100ps
`include "lpo_defs.vh"
module lpo_top_checker (
  input logic clk,
  input logic rst_b,
  input logic [7:0] addr,
  input logic [31:0] wdata,
  input logic wr_stb,
  input logic rd_stb,
  input logic [31:0] rdata,
  input logic [17:0] panel_data_out,
  input logic panel_valid,
  input logic pix_ready,
  input logic [4:0] active_width,
  input logic width_bad,
  input logic type_bad,
  input logic passive_sel
);
  logic [31:0] cfg_reg;
  logic [31:0] disp_reg;
  logic [6:0] age_reg;
  wire [1:0] pt = cfg_reg[1:0];
  wire [1:0] dw = cfg_reg[5:4];
  wire [4:0] exp_w = pt == 2'h0 ? 5'h4 << dw : (dw == 2'h0 ? 5'h9 : dw == 2'h1 ? 5'hC : 5'h12);
  // all-ones over the active lines; 18 lines wraps to the full mask
  wire [17:0] wmask = (18'h1 << active_width) - 18'h1;
  wire settled = age_reg > 7'h2;
  always @(posedge clk) begin
    if (!rst_b) begin
      cfg_reg <= 32'h0;
      disp_reg <= 32'h0;
      age_reg <= 7'h0;
    end else if (wr_stb) begin
      age_reg <= 7'h0;
      if (addr == `LPO_PANEL_CFG_ADDR) cfg_reg <= wdata & `LPO_CFG_MASK;
      if (addr == `LPO_DISP_SET_ADDR) disp_reg <= wdata & `LPO_DISP_MASK;
    end else if (age_reg != 7'h7F) begin
      age_reg <= age_reg + 7'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_rd_idle; !$past(rd_stb) |-> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_rd_disp; rd_stb && addr == `LPO_DISP_SET_ADDR |=> rdata == disp_reg; endproperty
  a_rd_disp: assert property (p_rd_disp) else $error("display settings readback");
  property p_width; settled && dw != 2'h3 && pt != 2'h2 |-> active_width == exp_w; endproperty
  a_width: assert property (p_width) else $error("active width wrong");
  property p_wbad; settled |-> width_bad == (dw == 2'h3); endproperty
  a_wbad: assert property (p_wbad) else $error("width code flag wrong");
  property p_tbad; settled |-> type_bad == (pt == 2'h2); endproperty
  a_tbad: assert property (p_tbad) else $error("type code flag wrong");
  property p_pass; settled |-> passive_sel == (pt == 2'h0); endproperty
  a_pass: assert property (p_pass) else $error("passive select wrong");
  property p_blank; panel_valid && age_reg > 7'h3F && disp_reg[23]
    |-> panel_data_out == (disp_reg[21] ^ disp_reg[20] ? wmask : 18'h0); endproperty
  a_blank: assert property (p_blank) else $error("blank level wrong");
  property p_hold; panel_valid && !pix_ready |=> panel_valid && $stable(panel_data_out); endproperty
  a_hold: assert property (p_hold) else $error("panel word dropped while stalled");
endmodule

// [verification/lpo_panel_model.sv]
// Purpose: panel stand-in that accepts output words
// Assumes: slow stalls two cycles of four, hold stalls completely
// Notes: accepted words are queued in got for the bench to compare
`timescale 1ns/100ps
module lpo_panel_model (
  input logic clk,
  input logic [17:0] panel_data_out,
  input logic panel_valid,
  input logic slow,
  input logic hold,
  output logic pix_ready
);
  logic [17:0] got[$];
  logic [1:0] cnt_reg = 2'h0;
  assign pix_ready = !hold && (!slow || cnt_reg[1]);
  always @(posedge clk) begin
    cnt_reg <= cnt_reg + 2'h1;
    if (panel_valid && pix_ready) got.push_back(panel_data_out);
  end
endmodule

// [verification/lpo_top_tb.sv]
// Purpose: register and pixel path tests for lpo_top
// Assumes: short line buffer of 8 pixels
// Notes: outputs are sampled at the falling edge to stay clear of updates
`timescale 1ns/100ps
`include "lpo_defs.vh"
module lpo_top_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [17:0] lut_pixel = 18'h0;
  logic lut_valid = 1'b0;
  logic line_end = 1'b0;
  logic slow = 1'b0;
  logic hold = 1'b0;
  wire [31:0] rdata;
  wire [17:0] panel_data_out;
  wire [4:0] active_width;
  wire lut_ready, panel_valid, pix_ready, width_bad, type_bad, passive_sel;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [17:0] exp_q[$];
  initial forever #2.5 clk = ~clk;
  lpo_top #(.LINE_MAX(8), .LW(3)) i_lpo_top (.clk, .rst_b, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .lut_pixel, .lut_valid, .lut_ready, .line_end, .panel_data_out, .panel_valid,
    .pix_ready, .active_width, .width_bad, .type_bad, .passive_sel);
  lpo_panel_model i_lpo_panel_model (.clk, .panel_data_out, .panel_valid, .slow, .hold,
    .pix_ready);
  task check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a; wdata <= d; wr_stb <= 1'b1;
    @(posedge clk); wr_stb <= 1'b0; @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    addr <= a; rd_stb <= 1'b1;
    @(posedge clk); rd_stb <= 1'b0;
    @(negedge clk); check(rdata & m, e);
    @(posedge clk);
  endtask
  // leaves valid high so back-to-back pixels need no gap
  task send(input logic [17:0] p, input logic e);
    int i;
    lut_pixel <= p; line_end <= e; lut_valid <= 1'b1; i = 0;
    do begin @(negedge clk); i++; end while (lut_ready !== 1'b1 && i < 300);
    if (i >= 300) begin n_mismatch++; finish_test; end
    @(posedge clk);
  endtask
  task drain;
    int i;
    for (i = 0; i < 2000 && i_lpo_panel_model.got.size() < exp_q.size(); i++) @(posedge clk);
    if (i >= 2000) begin n_mismatch++; finish_test; end
    while (exp_q.size() > 0) check(i_lpo_panel_model.got.pop_front(), exp_q.pop_front());
  endtask
  initial begin
    int t, d, m, k;
    logic [17:0] p;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(`LPO_DISP_SET_ADDR, 32'h0, '1);
    rd(`LPO_PANEL_CFG_ADDR, 32'h0, '1);
    wr(8'h40, '1);
    rd(8'h40, 32'h0, '1);
    wr(`LPO_DISP_SET_ADDR, 32'h03F0001F);
    rd(`LPO_DISP_SET_ADDR, 32'h03F0001F, '1);
    wr(`LPO_PANEL_CFG_ADDR, 32'hFFFFFFF7);
    rd(`LPO_PANEL_CFG_ADDR, 32'h33, '1);
    for (t = 0; t < 4; t++) for (d = 0; d < 4; d++) begin
      wr(`LPO_PANEL_CFG_ADDR, {26'h0, d[1:0], 2'h0, t[1:0]});
      repeat (3) @(negedge clk);
      check(width_bad, d == 3);
      check(type_bad, t == 2);
      if (t != 2 && d != 3)
        check(active_width, t == 0 ? 5'h4 << d : d == 2 ? 5'h12 : 5'h9 + 5'h3 * d);
      @(posedge clk);
    end
    wr(`LPO_PANEL_CFG_ADDR, 32'h21);
    for (m = 0; m < 8; m++) begin
      wr(`LPO_DISP_SET_ADDR, {8'h0, m[2], 1'b0, m[1], m[0], 20'h0});
      slow <= m[0];
      repeat (70) @(posedge clk);
      p = 18'h2A5C3 ^ m;
      exp_q.push_back(m[2] ? {18{m[1] ^ m[0]}} : m[0] ? ~p : p);
      send(p, 1'b1);
      lut_valid <= 1'b0;
      drain;
    end
    for (m = 0; m < 2; m++) begin
      wr(`LPO_DISP_SET_ADDR, 32'h01000000 << m);
      send(18'h00011, 1'b0);
      send(18'h3FF00, 1'b1);
      lut_valid <= 1'b0;
      if (m == 1) exp_q = '{18'h00011, 18'h3FF00, 18'h00011, 18'h3FF00};
      else exp_q = '{18'h00011, 18'h00011, 18'h3FF00, 18'h3FF00};
      drain;
    end
    wr(`LPO_PANEL_CFG_ADDR, 32'h20);
    wr(`LPO_DISP_SET_ADDR, 32'h00400000);
    send(18'h2A5C3, 1'b1);
    lut_valid <= 1'b0;
    exp_q.push_back(18'h2A5C3 & 18'h3CF3C & 18'h0FFFF);
    drain;
    wr(`LPO_PANEL_CFG_ADDR, 32'h21);
    wr(`LPO_DISP_SET_ADDR, 32'h0);
    hold <= 1'b1; lut_pixel <= 18'h15A5A; lut_valid <= 1'b1; line_end <= 1'b0; k = 0;
    repeat (60) begin @(negedge clk); if (lut_ready === 1'b1) k++; @(posedge clk); end
    lut_valid <= 1'b0;
    check(k >= 16, 1);
    rd(`LPO_STATUS_ADDR, 32'h1, 32'h1);
    hold <= 1'b0;
    // a stalled panel holds one word in the output stage plus a full buffer
    repeat (`LPO_FIFO_DEPTH + 1) exp_q.push_back(18'h15A5A);
    drain;
    rd(`LPO_STATUS_ADDR, 32'h0, 32'h11);
    finish_test;
  end
endmodule
bind lpo_top lpo_top_checker i_lpo_top_checker (.clk, .rst_b, .addr, .wdata, .wr_stb, .rd_stb,
  .rdata, .panel_data_out, .panel_valid, .pix_ready, .active_width, .width_bad, .type_bad,
  .passive_sel);
